// File: hdl/serial_port_pkg.sv
// serial port package: frame layout, timing defaults, carrier structs
// assumes a single 100 MHz system clock and synchronous active-high reset
// Functional notes
// R1 - transmit line idles high, disabled, loopback
// R2 - transmit lsb first, on serial clock fall
// R3 - receive assembled lsb first
// R4 - receive line change restarts stopped clock
// R5 - clear-to-send grants start of transmission
// R6 - request-to-send automatic or by queue level
// R7 - one low start, one high stop; the transmitter sends two stop bits when the last data bit is low
package serial_port_pkg;
  localparam int DATA_BITS = 8;
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD_DEFAULT = 115_200;
  localparam int OVERSAMPLE = 16;
  localparam int HALF_OVERSAMPLE = OVERSAMPLE / 2;
  localparam int QUEUE_DEPTH = 8;
  localparam int RTS_HIGH_WATER = 6;
  localparam logic LINE_MARK = 1'b1;
  localparam logic LINE_SPACE = 1'b0;

  typedef struct packed {
    logic enable;
    logic loopback;
    logic rts_by_level;
    logic rts_manual;
    logic clk_stop_req;
  } serial_cfg_t;

  typedef struct packed {
    logic tx_busy;
    logic rx_frame_err;
    logic clk_running;
    logic rx_overrun;
  } serial_stat_t;

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
endpackage : serial_port_pkg

// File: hdl/sync_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes one clock; write and read may happen in the same cycle
`timescale 1ns/10ps
`default_nettype none
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_wr_data,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  output logic [WIDTH-1:0] o_rd_data,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [$clog2(DEPTH+1)-1:0] o_level
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic do_wr;
  logic do_rd;

  assign o_wr_ready = (count_reg != CW'(DEPTH));
  assign o_rd_valid = (count_reg != '0);
  assign do_wr = i_wr_valid && o_wr_ready;
  assign do_rd = o_rd_valid && i_rd_ready;
  assign o_rd_data = mem[rd_ptr_reg];
  assign o_level = count_reg;

  always_ff @(posedge i_clk_sys) begin
    if (do_wr) begin
      mem[wr_ptr_reg] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count_reg <= count_reg + 1'b1;
      end else if (do_rd && !do_wr) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule : sync_fifo
`default_nettype wire

// File: hdl/async_serial_port.sv
// asynchronous serial port: transmitter, receiver, receive queue, handshake pins
// assumes serial pins asynchronous to i_clk_sys; config pins are on i_clk_sys
`timescale 1ns/10ps
`default_nettype none
module async_serial_port
  import serial_port_pkg::*;
#(
  parameter int BAUD = BAUD_DEFAULT,
  parameter int DEPTH = QUEUE_DEPTH,
  parameter int HIGH_WATER = RTS_HIGH_WATER
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire serial_port_pkg::serial_cfg_t i_cfg,
  input wire logic [DATA_BITS-1:0] i_tx_data,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  output logic [DATA_BITS-1:0] o_rx_data,
  output logic o_rx_valid,
  input wire logic i_rx_ready,
  input wire logic i_serial_rx_line,
  input wire logic i_clear_to_send_in_n,
  output logic o_serial_tx_line,
  output logic o_request_to_send_out_n,
  output serial_port_pkg::serial_stat_t o_status
);
  import serial_port_pkg::*;

  localparam int TICK_DIV = CLK_HZ / (BAUD * OVERSAMPLE);
  localparam int TW = $clog2(TICK_DIV + 1);
  localparam int BW = $clog2(DATA_BITS);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int PW = $clog2(OVERSAMPLE);

  // pin synchronisers
  logic rx_meta_reg;
  logic rx_sync_reg;
  logic rx_prev_reg;
  logic cts_meta_reg;
  logic cts_sync_reg;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rx_meta_reg <= LINE_MARK;
      rx_sync_reg <= LINE_MARK;
      rx_prev_reg <= LINE_MARK;
      cts_meta_reg <= 1'b1;
      cts_sync_reg <= 1'b1;
    end else begin
      rx_meta_reg <= i_serial_rx_line;
      rx_sync_reg <= rx_meta_reg;
      rx_prev_reg <= rx_sync_reg;
      cts_meta_reg <= i_clear_to_send_in_n;
      cts_sync_reg <= cts_meta_reg;
    end
  end

  // port clock gate: stop on request, restart on any receive edge
  logic clk_run_reg;
  logic rx_edge;
  assign rx_edge = rx_sync_reg != rx_prev_reg;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      clk_run_reg <= 1'b1;
    end else if (rx_edge) begin
      clk_run_reg <= 1'b1; // [R4]
    end else if (i_cfg.clk_stop_req) begin
      clk_run_reg <= 1'b0;
    end
  end

  // oversample tick, frozen while the port clock is stopped
  logic [TW-1:0] div_reg;
  logic tick;
  assign tick = clk_run_reg && (div_reg == TW'(TICK_DIV - 1));
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !clk_run_reg || tick) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // transmitter; line changes when phase wraps, i.e. serial clock falling edge
  tx_state_t tx_state_reg;
  logic [DATA_BITS-1:0] tx_shift_reg;
  logic [BW-1:0] tx_bit_reg;
  logic [PW-1:0] tx_phase_reg;
  logic tx_line_reg;
  logic tx_fall;
  logic tx_start_ok;
  assign tx_fall = tick && (tx_phase_reg == PW'(OVERSAMPLE - 1));
  assign tx_start_ok = i_cfg.enable && !i_cfg.loopback && !cts_sync_reg; // [R5]
  assign o_tx_ready = (tx_state_reg == TX_IDLE) && tx_start_ok;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      tx_state_reg <= TX_IDLE;
      tx_shift_reg <= '0;
      tx_bit_reg <= '0;
      tx_phase_reg <= '0;
      tx_line_reg <= LINE_MARK;
    end else begin
      if (tick) begin
        tx_phase_reg <= tx_phase_reg + 1'b1;
      end
      case (tx_state_reg)
        TX_IDLE: begin
          tx_line_reg <= LINE_MARK; // [R1]
          if (i_tx_valid && o_tx_ready) begin
            tx_shift_reg <= i_tx_data;
            tx_state_reg <= TX_START;
          end
        end
        TX_START: begin
          if (tx_fall) begin
            tx_line_reg <= LINE_SPACE; // [R7]
            tx_bit_reg <= '0;
            tx_state_reg <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (tx_fall) begin
            tx_line_reg <= tx_shift_reg[0]; // [R2]
            tx_shift_reg <= tx_shift_reg >> 1;
            tx_bit_reg <= tx_bit_reg + 1'b1;
            if (tx_bit_reg == BW'(DATA_BITS - 1)) begin
              tx_state_reg <= TX_STOP;
            end
          end
        end
        TX_STOP: begin
          if (tx_fall) begin
            if (tx_line_reg == LINE_MARK && tx_bit_reg == '0) begin
              tx_state_reg <= TX_IDLE;
            end
            tx_line_reg <= LINE_MARK; // [R7]
            tx_bit_reg <= '0;
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end
  // pin register; loopback keeps the pin at mark and feeds the receiver internally
  logic tx_pin_reg;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      tx_pin_reg <= LINE_MARK;
    end else if (i_cfg.loopback || !i_cfg.enable) begin
      tx_pin_reg <= LINE_MARK; // [R1]
    end else begin
      tx_pin_reg <= tx_line_reg;
    end
  end
  assign o_serial_tx_line = tx_pin_reg;

  // receiver
  logic rx_in;
  assign rx_in = i_cfg.loopback ? tx_line_reg : rx_sync_reg;
  rx_state_t rx_state_reg;
  logic [DATA_BITS-1:0] rx_shift_reg;
  logic [BW-1:0] rx_bit_reg;
  logic [PW-1:0] rx_phase_reg;
  logic rx_push_reg;
  logic rx_ferr_reg;
  logic rx_ovr_reg;
  logic q_wr_ready;
  logic [CW-1:0] q_level;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rx_state_reg <= RX_IDLE;
      rx_shift_reg <= '0;
      rx_bit_reg <= '0;
      rx_phase_reg <= '0;
      rx_push_reg <= 1'b0;
      rx_ferr_reg <= 1'b0;
      rx_ovr_reg <= 1'b0;
    end else begin
      rx_push_reg <= 1'b0;
      if (rx_push_reg && !q_wr_ready) begin
        rx_ovr_reg <= 1'b1;
      end
      case (rx_state_reg)
        RX_IDLE: begin
          rx_phase_reg <= '0;
          if (i_cfg.enable && rx_in == LINE_SPACE) begin
            rx_state_reg <= RX_START;
          end
        end
        RX_START: begin
          if (tick) begin
            rx_phase_reg <= rx_phase_reg + 1'b1;
            if (rx_phase_reg == PW'(HALF_OVERSAMPLE - 1)) begin
              rx_phase_reg <= '0;
              rx_bit_reg <= '0;
              rx_state_reg <= (rx_in == LINE_SPACE) ? RX_DATA : RX_IDLE; // [R7]
            end
          end
        end
        RX_DATA: begin
          if (tick) begin
            rx_phase_reg <= rx_phase_reg + 1'b1;
            if (rx_phase_reg == PW'(OVERSAMPLE - 1)) begin
              rx_shift_reg <= {rx_in, rx_shift_reg[DATA_BITS-1:1]}; // [R3]
              rx_bit_reg <= rx_bit_reg + 1'b1;
              if (rx_bit_reg == BW'(DATA_BITS - 1)) begin
                rx_state_reg <= RX_STOP;
              end
            end
          end
        end
        RX_STOP: begin
          if (tick) begin
            rx_phase_reg <= rx_phase_reg + 1'b1;
            if (rx_phase_reg == PW'(OVERSAMPLE - 1)) begin
              rx_ferr_reg <= (rx_in != LINE_MARK); // [R7]
              rx_push_reg <= (rx_in == LINE_MARK);
              rx_state_reg <= RX_IDLE;
            end
          end
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  sync_fifo #(
    .WIDTH(DATA_BITS),
    .DEPTH(DEPTH)
  ) u_receive_queue (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_wr_data(rx_shift_reg),
    .i_wr_valid(rx_push_reg),
    .o_wr_ready(q_wr_ready),
    .o_rd_data(o_rx_data),
    .o_rd_valid(o_rx_valid),
    .i_rd_ready(i_rx_ready),
    .o_level(q_level)
  );

  // request-to-send, active low: manual or while transmitting, or by receive queue level
  logic rts_n_reg;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rts_n_reg <= 1'b1;
    end else if (i_cfg.rts_by_level) begin
      rts_n_reg <= (q_level >= CW'(HIGH_WATER)); // [R6]
    end else begin
      rts_n_reg <= !(i_cfg.rts_manual || (tx_state_reg != TX_IDLE)); // [R6]
    end
  end
  assign o_request_to_send_out_n = rts_n_reg;

  assign o_status = '{
    tx_busy: (tx_state_reg != TX_IDLE),
    rx_frame_err: rx_ferr_reg,
    clk_running: clk_run_reg,
    rx_overrun: rx_ovr_reg
  };
endmodule : async_serial_port
`default_nettype wire

// File: dv/async_serial_port_assertions.sv
// checker for the serial port pins and handshakes
// assumes bind to async_serial_port, one clock, fast baud
`timescale 1ns/10ps
`default_nettype none
module async_serial_port_chk
  import serial_port_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire serial_port_pkg::serial_cfg_t i_cfg,
  input wire logic i_tx_valid,
  input wire logic o_tx_ready,
  input wire logic o_rx_valid,
  input wire logic i_serial_rx_line,
  input wire logic i_clear_to_send_in_n,
  input wire logic o_serial_tx_line,
  input wire logic o_request_to_send_out_n,
  input wire serial_port_pkg::serial_stat_t o_status
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  chk_line_mark_off: assert property ($past(!i_cfg.enable || i_cfg.loopback) |-> o_serial_tx_line)
    else $error("tx line low while off or looped");
  chk_ready_needs_cfg: assert property (o_tx_ready |-> i_cfg.enable && !i_cfg.loopback && !o_status.tx_busy && o_serial_tx_line)
    else $error("tx ready in wrong state");
  chk_accept_goes_busy: assert property (i_tx_valid && o_tx_ready |=> o_status.tx_busy && !o_tx_ready)
    else $error("accepted byte did not start a frame");
  chk_start_bit_soon: assert property (i_tx_valid && o_tx_ready |-> ##[1:40] !o_serial_tx_line)
    else $error("start bit missing");
  chk_bit_min_len: assert property ($fell(o_serial_tx_line) |-> !o_serial_tx_line [*8])
    else $error("low bit too short");
  chk_stop_bit_high: assert property ($fell(o_status.tx_busy) |-> o_serial_tx_line)
    else $error("frame ended low");
  chk_cts_blocks_tx: assert property (i_clear_to_send_in_n [*4] |-> !o_tx_ready)
    else $error("tx ready without clear to send");
  chk_rts_by_level: assert property ((i_cfg.rts_by_level && !o_rx_valid) [*2] |-> !o_request_to_send_out_n)
    else $error("rts not asserted with empty queue");
  chk_rts_manual_on: assert property ((!i_cfg.rts_by_level && i_cfg.rts_manual) [*2] |-> !o_request_to_send_out_n)
    else $error("manual rts not asserted");
  chk_rts_follows_tx: assert property ((!i_cfg.rts_by_level && !i_cfg.rts_manual) [*2] |-> (o_request_to_send_out_n == !$past(o_status.tx_busy)))
    else $error("automatic rts does not follow transmitter");
  chk_rx_edge_wakes: assert property (!o_status.clk_running && $changed(i_serial_rx_line) |-> ##[1:6] o_status.clk_running)
    else $error("rx edge did not restart clock");
endmodule : async_serial_port_chk
bind async_serial_port async_serial_port_chk u_chk (.i_clk_sys, .i_rst, .i_cfg, .i_tx_valid,
  .o_tx_ready, .o_rx_valid, .i_serial_rx_line, .i_clear_to_send_in_n, .o_serial_tx_line,
  .o_request_to_send_out_n, .o_status);
`default_nettype wire

// File: dv/remote_serial_peer.sv
// remote serial peer: sends frames on rx line, decodes tx line
// assumes BIT_CYC system clocks per bit, line driven idle high
`timescale 1ns/10ps
`default_nettype none
module remote_serial_peer #(
  parameter int BIT_CYC = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_line_in,
  input wire logic i_grant,
  output logic o_line_out,
  output logic o_clear_to_send_n
);
  logic [7:0] got_q[$];
  logic [7:0] sh;
  assign o_clear_to_send_n = !i_grant;
  initial o_line_out = 1'b1;
  // stop low makes a framing fault; the line returns to mark afterwards
  task automatic send_byte(input logic [7:0] d, input logic stop = 1'b1);
    logic [9:0] fr;
    fr = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge i_clk_sys);
      #1 o_line_out = fr[i];
      repeat (BIT_CYC - 1) @(posedge i_clk_sys);
    end
    #1 o_line_out = 1'b1;
  endtask : send_byte
  // mid-bit sampling, stop must be high to keep the byte
  always begin
    @(negedge i_line_in);
    repeat (BIT_CYC / 2) @(posedge i_clk_sys);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge i_clk_sys);
      sh[i] = i_line_in;
    end
    repeat (BIT_CYC) @(posedge i_clk_sys);
    if (i_line_in === 1'b1) got_q.push_back(sh);
  end
endmodule : remote_serial_peer
`default_nettype wire

// File: dv/tb.sv
// self-checking bench for the asynchronous serial port
// assumes the peer model and one oversample tick per system clock
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module tb;
  import serial_port_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  serial_cfg_t i_cfg = '0;
  logic [7:0] i_tx_data = 8'h00;
  logic i_tx_valid = 1'b0;
  logic i_rx_ready = 1'b0;
  logic grant = 1'b0;
  logic o_tx_ready, o_rx_valid, o_serial_tx_line, o_request_to_send_out_n, rx_line, cts_n;
  logic [7:0] o_rx_data, g, e;
  serial_stat_t o_status;
  int bad_count = 0;
  int total_checks = 0;
  logic [7:0] exp_q[$];
  always #5 i_clk_sys = ~i_clk_sys;
  async_serial_port #(.BAUD(6250000)) u_async_serial_port (.i_clk_sys, .i_rst, .i_cfg,
    .i_tx_data, .i_tx_valid, .o_tx_ready, .o_rx_data, .o_rx_valid, .i_rx_ready,
    .i_serial_rx_line(rx_line), .i_clear_to_send_in_n(cts_n), .o_serial_tx_line,
    .o_request_to_send_out_n, .o_status);
  remote_serial_peer #(.BIT_CYC(16)) u_peer (.i_clk_sys, .i_line_in(o_serial_tx_line),
    .i_grant(grant), .o_line_out(rx_line), .o_clear_to_send_n(cts_n));
  function automatic logic rts_expect(int lvl);
    return lvl >= RTS_HIGH_WATER;
  endfunction : rts_expect
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  task automatic cycles(int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : cycles
  // 0: tx ready, 1: rx valid, 2: peer holds nine bytes
  function automatic logic seen(int which);
    if (which == 0) return o_tx_ready;
    else if (which == 1) return o_rx_valid;
    else return u_peer.got_q.size() >= 9;
  endfunction : seen
  task automatic wait_for(input int which);
    int n;
    for (n = 0; n < 3000 && seen(which) !== 1'b1; n++) cycles(1);
    if (n == 3000) begin
      bad_count++;
      end_of_test();
    end
  endtask : wait_for
  task automatic tx_send(input logic [7:0] d);
    cycles(1);
    i_tx_data = d;
    i_tx_valid = 1'b1;
    wait_for(0);
    cycles(1);
    i_tx_valid = 1'b0;
    exp_q.push_back(d);
  endtask : tx_send
  task automatic rx_pop;
    wait_for(1);
    e = exp_q.pop_front();
    `CHK(o_rx_data, e)
    i_rx_ready = 1'b1;
    cycles(1);
    i_rx_ready = 1'b0;
    cycles(1);
  endtask : rx_pop
  initial begin
    void'($urandom(2));
    cycles(10);
    `CHK(o_serial_tx_line, LINE_MARK)
    i_rst = 1'b0;
    i_cfg.enable = 1'b1;
    i_tx_data = 8'hA5;
    i_tx_valid = 1'b1;
    cycles(50);
    `CHK(o_serial_tx_line, LINE_MARK)
    `CHK(o_status.tx_busy, 1'b0)
    grant = 1'b1;
    for (int i = 0; i < 9; i++) tx_send(i == 0 ? 8'hA5 : i == 1 ? 8'h00 : i == 2 ? 8'hFF : 8'($urandom));
    wait_for(2);
    while (exp_q.size() > 0) begin
      g = u_peer.got_q.size() > 0 ? u_peer.got_q.pop_front() : 8'hXX;
      e = exp_q.pop_front();
      `CHK(g, e)
    end
    i_cfg.loopback = 1'b1;
    cycles(3);
    `CHK(o_tx_ready, 1'b0)
    `CHK(o_serial_tx_line, LINE_MARK)
    i_cfg.loopback = 1'b0;
    i_cfg.rts_by_level = 1'b1;
    for (int i = 1; i <= 9; i++) begin
      e = 8'($urandom);
      if (i < 9) exp_q.push_back(e);
      u_peer.send_byte(e);
      cycles(3);
      `CHK(o_request_to_send_out_n, rts_expect(i > 8 ? 8 : i))
    end
    `CHK(o_status.rx_overrun, 1'b1)
    repeat (8) rx_pop();
    cycles(2);
    `CHK(o_request_to_send_out_n, rts_expect(0))
    u_peer.send_byte(8'h3C, 1'b0);
    cycles(20);
    `CHK(o_status.rx_frame_err, 1'b1)
    `CHK(o_rx_valid, 1'b0)
    e = 8'($urandom);
    exp_q.push_back(e);
    u_peer.send_byte(e);
    cycles(3);
    `CHK(o_status.rx_frame_err, 1'b0)
    rx_pop();
    i_cfg.rts_by_level = 1'b0;
    i_cfg.rts_manual = 1'b1;
    cycles(3);
    `CHK(o_request_to_send_out_n, 1'b0)
    i_cfg.clk_stop_req = 1'b1;
    cycles(20);
    `CHK(o_status.clk_running, 1'b0)
    i_cfg.clk_stop_req = 1'b0;
    cycles(3);
    `CHK(o_status.clk_running, 1'b0)
    exp_q.push_back(8'h55);
    fork
      u_peer.send_byte(8'h55);
    join_none
    cycles(6);
    `CHK(o_status.clk_running, 1'b1)
    cycles(170);
    rx_pop();
    i_rst = 1'b1;
    cycles(2);
    `CHK(o_status.rx_overrun, 1'b0)
    `CHK(o_request_to_send_out_n, 1'b1)
    i_rst = 1'b0;
    cycles(3);
    `CHK(o_request_to_send_out_n, 1'b0)
    end_of_test();
  end
endmodule : tb
`default_nettype wire
